// ### rtl/phy_event_pkg.sv
// Package of register offsets, field positions and reset values for the event block
//
// Summary of operation
// - Status bit latches event until register read, jabber until reset
// - Interrupt needs enable plus both global bits
// - Status latches even with enable cleared
// - Register one pending bits 13 to 8
// - Register one enables bits 5:0, reset 0
// - Register two pending 14:8, jabber not cleared
// - Register two enables bits 6:0, reset 0
// - Reserved bits ignore writes, read zero
// - False-carrier count 8 bits, saturates FFh
// - False-carrier above 7Fh raises half-full event
// - Reading a counter returns it then clears
// - Receive errors counted with carrier and valid
// - No receive-error counting in MII loopback
// - Receive-error counter saturates at FFFFh
// - Receive-error above 7FFFh raises half-full event
// - Register one pending link 13, speed 12
// - Polarity bit, reset 1, idle-high output
// - Test bit forces interrupt asserted
// - Output-enable bit selects interrupt or power-down
`default_nettype none

package phy_event_pkg;
    // ======================================================================
    // Register indices (byte address is four times the index)
    localparam logic [7:0] IDX_SPECIAL_CONTROL = 8'h11;
    localparam logic [7:0] IDX_STATUS_ONE      = 8'h12;
    localparam logic [7:0] IDX_STATUS_TWO      = 8'h13;
    localparam logic [7:0] IDX_FALSE_CARRIER   = 8'h14;
    localparam logic [7:0] IDX_RX_ERROR        = 8'h15;
    localparam int         ADDR_WIDTH          = 10;

    // ======================================================================
    // Field positions
    localparam int ONE_PEND_LSB  = 8;   // pending 13:8
    localparam int TWO_PEND_LSB  = 8;   // pending 14:8
    localparam int ONE_EVENTS    = 6;
    localparam int TWO_EVENTS    = 7;
    localparam int CTL_OE_BIT    = 0;
    localparam int CTL_IEN_BIT   = 1;
    localparam int CTL_TEST_BIT  = 2;
    localparam int CTL_POL_BIT   = 3;
    localparam int CTL_WIDTH     = 4;

    // ======================================================================
    // Reset values and thresholds
    localparam logic [3:0]  CTL_RESET     = 4'h8;      // polarity high
    localparam logic [15:0] FC_HALF       = 16'h007f;
    localparam logic [15:0] RE_HALF       = 16'h7fff;
    localparam logic [15:0] UNMAPPED_DATA = 16'h0000;
endpackage : phy_event_pkg

`default_nettype wire

// ### rtl/sat_counter.sv
// Saturating event counter with clear and half-full flag
`default_nettype none

module sat_counter #(
    parameter int WIDTH = 16
) (
    // Clock and reset
    input  wire logic             clk_sys,
    input  wire logic             reset,
    // Control
    input  wire logic             count_en,
    input  wire logic             clear,
    input  wire logic [WIDTH-1:0] half_level,
    // Status
    output logic      [WIDTH-1:0] value,
    output logic                  over_half
);
    wire logic             at_max;
    wire logic [WIDTH-1:0] next_value;

    // Stop at all ones rather than wrap
    assign at_max     = &value;
    assign next_value = clear ? '0
                      : (count_en && !at_max) ? value + WIDTH'(1) : value;
    assign over_half  = value > half_level;

    // Clear wins: a count in the read cycle is lost, keeping read+clear atomic
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            value <= '0;
        end else begin
            value <= next_value;
        end
    end
endmodule : sat_counter

`default_nettype wire

// ### rtl/phy_event_status.sv
// Event status, interrupt enables, special control bits and error counters
//
// Register access over Avalon-MM was chosen for this implementation.
`default_nettype none

module phy_event_status
    import phy_event_pkg::*;
#(
    parameter int FC_WIDTH = 8,
    parameter int RE_WIDTH = 16
) (
    // Clock and reset
    input  wire logic                                clk_sys,
    input  wire logic                                reset,
    // Avalon-MM slave
    input  wire logic [phy_event_pkg::ADDR_WIDTH-1:0] address,
    input  wire logic                                read,
    input  wire logic                                write,
    input  wire logic [31:0]                         writedata,
    input  wire logic [3:0]                          byteenable,
    output logic      [31:0]                         readdata,
    output logic                                     waitrequest,
    // Register one events, one-cycle pulses
    input  wire logic                                link_change,
    input  wire logic                                speed_change,
    input  wire logic                                duplex_change,
    input  wire logic                                autoneg_done,
    // Register two events, one-cycle pulses
    input  wire logic                                autoneg_error,
    input  wire logic                                page_received,
    input  wire logic                                loop_fifo_error,
    input  wire logic                                crossover_change,
    input  wire logic                                sleep_event,
    input  wire logic                                polarity_change,
    input  wire logic                                jabber_detect,
    // Receive path
    input  wire logic                                false_carrier,
    input  wire logic                                carrier_valid,
    input  wire logic                                rx_data_valid,
    input  wire logic                                invalid_symbol,
    input  wire logic                                mii_loopback,
    // Shared interrupt / power-down pin
    input  wire logic                                irq_powerdown_pin_in,
    output logic                                     irq_powerdown_pin_out,
    output logic                                     irq_powerdown_pin_oe,
    output logic                                     powerdown_request
);
    // ======================================================================
    // Bus decode
    // Index is the word address; the low two byte bits are ignored
    wire logic [7:0]  reg_index;
    wire logic        hit_ctl;
    wire logic        hit_one;
    wire logic        hit_two;
    wire logic        hit_fc;
    wire logic        hit_re;
    wire logic        low_lane;
    wire logic        high_lane;
    logic             read_done;

    assign reg_index = address[phy_event_pkg::ADDR_WIDTH-1:2];
    assign hit_ctl   = reg_index == IDX_SPECIAL_CONTROL;
    assign hit_one   = reg_index == IDX_STATUS_ONE;
    assign hit_two   = reg_index == IDX_STATUS_TWO;
    assign hit_fc    = reg_index == IDX_FALSE_CARRIER;
    assign hit_re    = reg_index == IDX_RX_ERROR;
    assign low_lane  = byteenable[0];
    assign high_lane = byteenable[1];

    // Reads take two cycles so read data come from flops; writes take one
    assign waitrequest = read && !read_done;

    // Capture strobe: the clear-on-read lands on the edge that captures
    // the data, so a flag event seen in the wait cycle stays pending; a counter increment there is lost
    wire logic read_take;
    assign read_take = read && !read_done;

    // ======================================================================
    // Control bits (irq enable, output enable, test, polarity)
    logic [CTL_WIDTH-1:0] ctl;
    wire  logic           ctl_wr;
    assign ctl_wr = write && hit_ctl && low_lane;

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            ctl <= CTL_RESET;
        end else if (ctl_wr) begin
            ctl <= writedata[CTL_WIDTH-1:0];
        end
    end

    // ======================================================================
    // Enable registers, low byte lane only; reserved bits never stored
    logic [ONE_EVENTS-1:0] en_one;
    logic [TWO_EVENTS-1:0] en_two;

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            en_one <= '0;
            en_two <= '0;
        end else begin
            if (write && hit_one && low_lane) begin
                en_one <= writedata[ONE_EVENTS-1:0];
            end
            if (write && hit_two && low_lane) begin
                en_two <= writedata[TWO_EVENTS-1:0];
            end
        end
    end

    // ======================================================================
    // Error counters
    logic [FC_WIDTH-1:0] fc_value;
    logic [RE_WIDTH-1:0] re_value;
    wire  logic          fc_over;
    wire  logic          re_over;
    wire  logic          re_count;

    // Loopback traffic is not line traffic, so its receive errors are never counted
    assign re_count = carrier_valid && rx_data_valid && invalid_symbol
                    && !mii_loopback;

    sat_counter #(
        .WIDTH      (FC_WIDTH)
    ) u_false_carrier (
        .clk_sys    (clk_sys),
        .reset      (reset),
        .count_en   (false_carrier),
        .clear      (read_take && hit_fc),
        .half_level (FC_HALF[FC_WIDTH-1:0]),
        .value      (fc_value),
        .over_half  (fc_over)
    );

    sat_counter #(
        .WIDTH      (RE_WIDTH)
    ) u_rx_error (
        .clk_sys    (clk_sys),
        .reset      (reset),
        .count_en   (re_count),
        .clear      (read_take && hit_re),
        .half_level (RE_HALF[RE_WIDTH-1:0]),
        .value      (re_value),
        .over_half  (re_over)
    );

    // Half-full is an event on the rising crossing, not a level
    logic fc_over_d;
    logic re_over_d;
    wire  logic fc_half_event;
    wire  logic re_half_event;
    assign fc_half_event = fc_over && !fc_over_d;
    assign re_half_event = re_over && !re_over_d;

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            fc_over_d <= 1'b0;
            re_over_d <= 1'b0;
        end else begin
            fc_over_d <= fc_over;
            re_over_d <= re_over;
        end
    end

    // ======================================================================
    // Pending flags: link, speed, duplex, autoneg, fc half, re half
    wire  logic [ONE_EVENTS-1:0] ev_one;
    wire  logic [TWO_EVENTS-1:0] ev_two;
    logic [ONE_EVENTS-1:0]       pend_one;
    logic [TWO_EVENTS-1:0]       pend_two;
    wire  logic [TWO_EVENTS-1:0] two_clear_mask;
    wire  logic [ONE_EVENTS-1:0] next_pend_one;
    wire  logic [TWO_EVENTS-1:0] next_pend_two;

    assign ev_one = {link_change, speed_change, duplex_change,
                     autoneg_done, fc_half_event, re_half_event};
    assign ev_two = {autoneg_error, page_received, loop_fifo_error,
                     crossover_change, sleep_event, polarity_change,
                     jabber_detect};
    // Jabber (bit 0) is not cleared by a read
    assign two_clear_mask = {{(TWO_EVENTS-1){1'b1}}, 1'b0};

    // Event sets win over the read clear so nothing is lost; flags latch
    // regardless of the enables so software can poll
    assign next_pend_one = (read_take && hit_one)
                         ? ev_one : (pend_one | ev_one);
    assign next_pend_two = (read_take && hit_two)
                         ? ((pend_two & ~two_clear_mask) | ev_two)
                         : (pend_two | ev_two);

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            pend_one <= '0;
            pend_two <= '0;
        end else begin
            pend_one <= next_pend_one;
            pend_two <= next_pend_two;
        end
    end

    // ======================================================================
    // Read data mux, reserved bits forced to zero
    logic [15:0]      rd_word;
    always_comb begin
        rd_word = UNMAPPED_DATA;
        if (hit_ctl) begin
            rd_word[CTL_WIDTH-1:0] = ctl;
        end else if (hit_one) begin
            rd_word[ONE_PEND_LSB +: ONE_EVENTS] = pend_one;
            rd_word[ONE_EVENTS-1:0] = en_one;
        end else if (hit_two) begin
            rd_word[TWO_PEND_LSB +: TWO_EVENTS] = pend_two;
            rd_word[TWO_EVENTS-1:0] = en_two;
        end else if (hit_fc) begin
            rd_word[FC_WIDTH-1:0] = fc_value;
        end else if (hit_re) begin
            rd_word[RE_WIDTH-1:0] = re_value;
        end
    end

    // Data captured in the wait cycle and shown with waitrequest low
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            read_done <= 1'b0;
            readdata  <= 32'h0000_0000;
        end else begin
            read_done <= read_take;
            if (read_take) begin
                readdata <= {16'h0000, rd_word};
            end
        end
    end

    // ======================================================================
    // Interrupt: level while any enabled flag stays pending
    wire logic any_enabled;
    wire logic irq_active;
    assign any_enabled = |(pend_one & en_one) | |(pend_two & en_two);
    assign irq_active  = (any_enabled && ctl[CTL_IEN_BIT]
                          && ctl[CTL_OE_BIT])
                       || ctl[CTL_TEST_BIT];

    // Output flops keep the pin free of decode glitches
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            irq_powerdown_pin_out <= 1'b1;
            irq_powerdown_pin_oe  <= 1'b0;
            powerdown_request     <= 1'b0;
        end else begin
            irq_powerdown_pin_out <= irq_active ^ ctl[CTL_POL_BIT];
            irq_powerdown_pin_oe  <= ctl[CTL_OE_BIT];
            // Pin is an active-low power-down input when not driven
            powerdown_request     <= !ctl[CTL_OE_BIT]
                                     && !irq_powerdown_pin_in;
        end
    end

    // High byte lane is never used; writes there would hit only pending, reserved or receive-error count bits
    wire logic unused_lanes;
    assign unused_lanes = high_lane ^ (^byteenable[3:2]) ^ (^writedata[31:8]);
endmodule : phy_event_status

`default_nettype wire

// ### verification/phy_event_status_assertions.sv
// Checker for bus timing, reserved bits and pin behaviour
`default_nettype none

module phy_event_status_assertions
    import phy_event_pkg::*;
(
    // Clock and reset
    input wire logic                                 clk_sys,
    input wire logic                                 reset,
    // Bus
    input wire logic [phy_event_pkg::ADDR_WIDTH-1:0] address,
    input wire logic                                 read,
    input wire logic                                 write,
    input wire logic [31:0]                          writedata,
    input wire logic [3:0]                           byteenable,
    input wire logic [31:0]                          readdata,
    input wire logic                                 waitrequest,
    // Pin
    input wire logic                                 irq_powerdown_pin_in,
    input wire logic                                 irq_powerdown_pin_out,
    input wire logic                                 irq_powerdown_pin_oe,
    input wire logic                                 powerdown_request
);
    // ======================================================================
    // Control shadow; the age lets the pin settle after a write
    logic [3:0] ctl_q;
    logic [1:0] ctl_age;
    wire logic [7:0] idx;
    wire logic       ctl_wr;
    wire logic       done;
    assign idx    = address[9:2];
    assign ctl_wr = write && byteenable[0] && idx == IDX_SPECIAL_CONTROL;
    assign done   = read && !waitrequest;

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            ctl_q   <= CTL_RESET;
            ctl_age <= 2'h2;
        end else if (ctl_wr) begin
            ctl_q   <= writedata[3:0];
            ctl_age <= 2'h0;
        end else if (ctl_age != 2'h2) begin
            ctl_age <= ctl_age + 2'h1;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    // ======================================================================
    // Properties
    property p_read_wait;
        $rose(read) |-> waitrequest ##1 !waitrequest;
    endproperty
    a_read_wait: assert property (p_read_wait)
        else $error("read wait state wrong");
    property p_write_nowait;
        write |-> !waitrequest;
    endproperty
    a_write_nowait: assert property (p_write_nowait)
        else $error("write stalled");
    property p_fc_reserved;
        done && idx == IDX_FALSE_CARRIER |-> readdata[31:8] == 24'h00_0000;
    endproperty
    a_fc_reserved: assert property (p_fc_reserved)
        else $error("counter reserved bits set");
    property p_one_reserved;
        done && idx == IDX_STATUS_ONE
            |-> readdata[15:14] == 2'h0 && readdata[7:6] == 2'h0;
    endproperty
    a_one_reserved: assert property (p_one_reserved)
        else $error("status one reserved bits set");
    property p_two_reserved;
        done && idx == IDX_STATUS_TWO |-> !readdata[15] && !readdata[7];
    endproperty
    a_two_reserved: assert property (p_two_reserved)
        else $error("status two reserved bits set");
    property p_oe_follow;
        ctl_age == 2'h2 |-> irq_powerdown_pin_oe == ctl_q[CTL_OE_BIT];
    endproperty
    a_oe_follow: assert property (p_oe_follow)
        else $error("pin enable differs from control");
    property p_test_force;
        ctl_age == 2'h2 && ctl_q[CTL_TEST_BIT]
            |-> irq_powerdown_pin_out == !ctl_q[CTL_POL_BIT];
    endproperty
    a_test_force: assert property (p_test_force)
        else $error("test bit did not force interrupt");
    property p_no_global;
        ctl_age == 2'h2 && !ctl_q[CTL_TEST_BIT]
            && !(ctl_q[CTL_IEN_BIT] && ctl_q[CTL_OE_BIT])
            |-> irq_powerdown_pin_out == ctl_q[CTL_POL_BIT];
    endproperty
    a_no_global: assert property (p_no_global)
        else $error("interrupt without global enables");
    property p_pd_block;
        $past(irq_powerdown_pin_oe) && irq_powerdown_pin_oe
            |-> !powerdown_request;
    endproperty
    a_pd_block: assert property (p_pd_block)
        else $error("power-down while pin is an output");

    c_read: cover property (done);
    c_irq: cover property (irq_powerdown_pin_oe && !irq_powerdown_pin_out);
    c_pd: cover property (powerdown_request);
endmodule : phy_event_status_assertions

bind phy_event_status phy_event_status_assertions
    phy_event_status_assertions_inst (
    .clk_sys(clk_sys), .reset(reset), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable),
    .readdata(readdata), .waitrequest(waitrequest),
    .irq_powerdown_pin_in(irq_powerdown_pin_in),
    .irq_powerdown_pin_out(irq_powerdown_pin_out),
    .irq_powerdown_pin_oe(irq_powerdown_pin_oe),
    .powerdown_request(powerdown_request));

`default_nettype wire

// ### verification/phy_event_status_bench.sv
// Self-checking bench for the event status block
`default_nettype none

module phy_event_status_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import phy_event_pkg::*;

    // ======================================================================
    // Stimulus and observed signals
    logic                  clk_sys   = 1'b0;
    logic                  reset     = 1'b1;
    logic [ADDR_WIDTH-1:0] address   = '0;
    logic                  read      = 1'b0;
    logic                  write     = 1'b0;
    logic [31:0]           writedata = '0;
    logic [10:0]           ev        = '0;  // link first, jabber last
    logic [4:0]            rx        = '0;  // fc, carrier, dv, symbol, loop
    logic                  pin_in    = 1'b1;
    logic [31:0]           readdata, rdat;
    logic                  waitrequest, pin_out, pin_oe, pd_req;
    int                    err_total = 0, num_checks = 0, cycles = 0;

    phy_event_status phy_event_status_inst (
        .clk_sys(clk_sys), .reset(reset), .address(address), .read(read),
        .write(write), .writedata(writedata), .byteenable(4'h1),
        .readdata(readdata), .waitrequest(waitrequest),
        .link_change(ev[10]), .speed_change(ev[9]), .duplex_change(ev[8]),
        .autoneg_done(ev[7]), .autoneg_error(ev[6]), .page_received(ev[5]),
        .loop_fifo_error(ev[4]), .crossover_change(ev[3]),
        .sleep_event(ev[2]), .polarity_change(ev[1]), .jabber_detect(ev[0]),
        .false_carrier(rx[4]), .carrier_valid(rx[3]), .rx_data_valid(rx[2]),
        .invalid_symbol(rx[1]), .mii_loopback(rx[0]),
        .irq_powerdown_pin_in(pin_in), .irq_powerdown_pin_out(pin_out),
        .irq_powerdown_pin_oe(pin_oe), .powerdown_request(pd_req));

    // ======================================================================
    // Clock, and a ceiling well above the long counter run
    initial begin
        forever #12.5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 90000) begin
            err_total++;
            end_of_test();
        end
    end

    // ======================================================================
    // Shared tasks
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : end_of_test
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // Request held until the rising edge that sees waitrequest low
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        @(posedge clk_sys);
        address   <= {idx, 2'h0};
        writedata <= 32'(d);
        write     <= 1'b1;
        do @(posedge clk_sys); while (waitrequest !== 1'b0);
        write <= 1'b0;
    endtask : wr
    // Read data taken at the same edge that sees waitrequest low
    task automatic rd(input logic [7:0] idx, input logic [15:0] exp);
        @(posedge clk_sys);
        address <= {idx, 2'h0};
        read    <= 1'b1;
        do @(posedge clk_sys); while (waitrequest !== 1'b0);
        rdat = readdata;
        read <= 1'b0;
        chk(rdat, 32'(exp));
    endtask : rd
    task automatic pulse(input logic [10:0] v);
        @(posedge clk_sys);
        ev <= v;
        @(posedge clk_sys);
        ev <= '0;
    endtask : pulse
    task automatic hold(input logic [4:0] v, input int n);
        @(posedge clk_sys);
        rx <= v;
        repeat (n) @(posedge clk_sys);
        rx <= '0;
    endtask : hold
    // Power-down request and pin level after they settle
    task automatic pin(input logic [1:0] exp);
        repeat (3) @(negedge clk_sys);
        chk(32'({pd_req, pin_out}), 32'(exp));
    endtask : pin

    // ======================================================================
    // Scenarios
    task automatic t_reset();
        @(negedge clk_sys);
        chk(32'({pin_oe, pin_out}), 32'h1);
        rd(IDX_STATUS_ONE, 16'h0000);
        rd(IDX_STATUS_TWO, 16'h0000);
        wr(IDX_FALSE_CARRIER, 8'hff);
        rd(IDX_FALSE_CARRIER, 16'h0000);
        wr(8'h20, 8'hff);
        rd(8'h20, 16'h0000);
        $display("reset test done");
    endtask : t_reset
    task automatic t_status();
        pulse(11'h780);
        rd(IDX_STATUS_ONE, 16'h3c00);
        rd(IDX_STATUS_ONE, 16'h0000);
        wr(IDX_STATUS_ONE, 8'hff);
        rd(IDX_STATUS_ONE, 16'h003f);
        pulse(11'h07f);
        wr(IDX_STATUS_TWO, 8'hff);
        rd(IDX_STATUS_TWO, 16'h7f7f);
        rd(IDX_STATUS_TWO, 16'h017f);
        @(posedge clk_sys);
        reset <= 1'b1;
        repeat (16) @(posedge clk_sys);
        reset <= 1'b0;
        $display("status test done");
    endtask : t_status
    task automatic t_irq();
        wr(IDX_SPECIAL_CONTROL, 8'h0b);
        wr(IDX_STATUS_ONE, 8'h20);
        pin(2'h1);
        pulse(11'h400);
        pin(2'h0);
        rd(IDX_STATUS_ONE, 16'h2020);
        pin(2'h1);
        wr(IDX_SPECIAL_CONTROL, 8'h09);
        pulse(11'h400);
        pin(2'h1);
        rd(IDX_STATUS_ONE, 16'h2020);
        wr(IDX_SPECIAL_CONTROL, 8'h04);
        pin(2'h1);
        @(posedge clk_sys);
        pin_in <= 1'b0;
        wr(IDX_SPECIAL_CONTROL, 8'h00);
        pin(2'h2);
        wr(IDX_SPECIAL_CONTROL, 8'h01);
        pin(2'h0);
        @(posedge clk_sys);
        pin_in <= 1'b1;
        $display("interrupt test done");
    endtask : t_irq
    task automatic t_count();
        hold(5'h10, 128);
        rd(IDX_FALSE_CARRIER, 16'h0080);
        rd(IDX_STATUS_ONE, 16'h0220);
        rd(IDX_FALSE_CARRIER, 16'h0000);
        hold(5'h10, 300);
        rd(IDX_FALSE_CARRIER, 16'h00ff);
        rd(IDX_STATUS_ONE, 16'h0220);
        hold(5'h0f, 5);
        hold(5'h0a, 5);
        rd(IDX_RX_ERROR, 16'h0000);
        hold(5'h0e, 5);
        rd(IDX_RX_ERROR, 16'h0005);
        hold(5'h0e, 65540);
        rd(IDX_RX_ERROR, 16'hffff);
        rd(IDX_STATUS_ONE, 16'h0120);
        $display("counter test done");
    endtask : t_count

    initial begin
        repeat (16) @(posedge clk_sys);
        reset <= 1'b0;
        t_reset();
        t_status();
        t_irq();
        t_count();
        end_of_test();
    end
endmodule : phy_event_status_bench

`default_nettype wire
